// *** inc/phase_bus.sv ***
`timescale 1ns/1ps
interface phase_bus;
  logic [3:0] phase;
  logic [3:0] enter;
  logic hold;
  modport gen (output phase, output enter, output hold);
  modport core (input phase, input enter, input hold);
endinterface

// *** inc/qclk_pkg.sv ***
package qclk_pkg;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int PC_WIDTH = 11;
  localparam int INSTR_WIDTH = 12;
  localparam logic [PC_WIDTH-1:0] PC_RESET = 11'h000;
  localparam logic [PC_WIDTH-1:0] PC_STEP = 11'h001;
  localparam logic [INSTR_WIDTH-1:0] INSTR_RESET = 12'h000;

  // ----------------------------------------------------------------
  // Phase vector bit positions
  // ----------------------------------------------------------------
  localparam int NUM_PHASES = 4;
  localparam int PH_IDX_ONE = 0;
  localparam int PH_IDX_TWO = 1;
  localparam int PH_IDX_THREE = 2;
  localparam int PH_IDX_FOUR = 3;
  localparam logic [NUM_PHASES-1:0] PHASE_NONE = 4'h0;
  localparam logic [NUM_PHASES-1:0] PHASE_ONE_HOT = 4'h1;
  localparam logic [NUM_PHASES-1:0] PHASE_TWO_HOT = 4'h2;
  localparam logic [NUM_PHASES-1:0] PHASE_THREE_HOT = 4'h4;
  localparam logic [NUM_PHASES-1:0] PHASE_FOUR_HOT = 4'h8;

  // ----------------------------------------------------------------
  // Oscillator selection codes
  // ----------------------------------------------------------------
  localparam logic [1:0] OSC_SEL_LOW_POWER = 2'h0;
  localparam logic [1:0] OSC_SEL_CRYSTAL = 2'h1;
  localparam logic [1:0] OSC_SEL_HIGH_SPEED = 2'h2;
  localparam logic [1:0] OSC_SEL_RC = 2'h3;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_ONE,
    PH_TWO,
    PH_THREE,
    PH_FOUR
  } phase_t;

  typedef enum logic [1:0] {
    LOW_POWER_CRYSTAL_MODE,
    CRYSTAL_RESONATOR_MODE,
    HIGH_SPEED_CRYSTAL_MODE,
    RC_OSCILLATOR_MODE
  } osc_mode_t;

endpackage

// *** src/quad_phase_gen.sv ***
`timescale 1ns/1ps
module quad_phase_gen
  import qclk_pkg::*;
(
  input wire logic clk,            // System clock
  input wire logic rst_n,          // Asynchronous reset
  input wire logic osc_in,         // Oscillator input pin
  input wire logic master_clear_n, // Master clear pin
  phase_bus.gen pb                 // Phases to the core
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic osc_s1_q, osc_s2_q, osc_s3_q;
  logic master_clear_n_s1_q, master_clear_n_s2_q;
  logic osc_rise;
  phase_t state_q, state_d;
  logic [NUM_PHASES-1:0] phase_d;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
    end else begin
      osc_s1_q <= osc_in;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
    end
  end

  // Held in reset until the clear pin is seen high twice
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      master_clear_n_s1_q <= 1'b0;
      master_clear_n_s2_q <= 1'b0;
      pb.hold <= 1'b1;
    end else begin
      master_clear_n_s1_q <= master_clear_n;
      master_clear_n_s2_q <= master_clear_n_s1_q;
      pb.hold <= !master_clear_n_s2_q;
    end
  end

  assign osc_rise = osc_s2_q && !osc_s3_q;

  // ----------------------------------------------------------------
  // Divide by four
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    if (osc_rise) begin
      case (state_q)
        PH_IDLE: state_d = PH_ONE;
        PH_ONE: state_d = PH_TWO;
        PH_TWO: state_d = PH_THREE;
        PH_THREE: state_d = PH_FOUR;
        PH_FOUR: state_d = PH_ONE;
        default: state_d = PH_IDLE;
      endcase
    end
    case (state_d)
      PH_ONE: phase_d = PHASE_ONE_HOT;
      PH_TWO: phase_d = PHASE_TWO_HOT;
      PH_THREE: phase_d = PHASE_THREE_HOT;
      PH_FOUR: phase_d = PHASE_FOUR_HOT;
      default: phase_d = PHASE_NONE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= PH_IDLE;
      pb.phase <= PHASE_NONE;
      pb.enter <= PHASE_NONE;
    end else if (pb.hold) begin
      state_q <= PH_IDLE;
      pb.phase <= PHASE_NONE;
      pb.enter <= PHASE_NONE;
    end else begin
      state_q <= state_d;
      pb.phase <= phase_d;
      pb.enter <= osc_rise ? phase_d : PHASE_NONE;
    end
  end

  a_phase_exclusive: assert property (
    @(posedge clk) disable iff (!rst_n) $onehot0(pb.phase))
    else $error("phases overlap");

  a_phase_order: assert property (
    @(posedge clk) disable iff (!rst_n)
    pb.enter[PH_IDX_TWO] |-> $past(pb.phase[PH_IDX_ONE]))
    else $error("phase two did not follow phase one");

endmodule

// *** src/quadrature_clock_pipeline.sv ***
`timescale 1ns/1ps
module quadrature_clock_pipeline
  import qclk_pkg::*;
(
  input wire logic clk,                           // 40 MHz clock
  input wire logic rst_n,                         // Asynchronous reset
  input wire logic osc_in,                        // Oscillator pin
  input wire logic master_clear_n,                // Master clear pin
  input wire logic [1:0] osc_select_bits,         // Oscillator config
  input wire logic [INSTR_WIDTH-1:0] prog_data,   // Program memory word
  input wire logic branch_req,                    // Executing op jumps
  input wire logic [PC_WIDTH-1:0] branch_target,  // Jump address
  output logic phase_one,                         // Phase one level
  output logic phase_two,                         // Phase two level
  output logic phase_three,                       // Phase three level
  output logic phase_four,                        // Phase four level
  output logic [PC_WIDTH-1:0] prog_addr,          // Address being fetched
  output logic [INSTR_WIDTH-1:0] instr_reg,       // Executing instruction
  output logic exec_valid,                        // instr_reg is live
  output logic pc_step,                           // PC advanced pulse
  output logic dmem_read,                         // Operand read pulse
  output logic dmem_write,                        // Result write pulse
  output logic cycle_clock_out,                   // Cycle rate clock
  output logic lp_mode,                           // Low-power crystal
  output logic xt_mode,                           // Standard crystal
  output logic hs_mode,                           // High-speed crystal
  output logic rc_mode                            // RC oscillator
);

  phase_bus pb();

  quad_phase_gen u_phase (
    .clk(clk),
    .rst_n(rst_n),
    .osc_in(osc_in),
    .master_clear_n(master_clear_n),
    .pb(pb.gen)
  );

  assign phase_one = pb.phase[PH_IDX_ONE];
  assign phase_two = pb.phase[PH_IDX_TWO];
  assign phase_three = pb.phase[PH_IDX_THREE];
  assign phase_four = pb.phase[PH_IDX_FOUR];

  // ----------------------------------------------------------------
  // Oscillator mode
  // ----------------------------------------------------------------
  osc_mode_t osc_mode_q;
  logic [PC_WIDTH-1:0] pc_q;
  logic [PC_WIDTH-1:0] prog_addr_q;
  logic [INSTR_WIDTH-1:0] fetch_q;
  logic fetch_valid_q;
  logic [INSTR_WIDTH-1:0] ir_q;
  logic exec_valid_q;
  logic pc_step_q, dmem_read_q, dmem_write_q, cycle_clock_q;
  logic take_branch;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_mode_q <= LOW_POWER_CRYSTAL_MODE;
    end else begin
      if (osc_select_bits == OSC_SEL_LOW_POWER) begin
        osc_mode_q <= LOW_POWER_CRYSTAL_MODE;
      end else if (osc_select_bits == OSC_SEL_CRYSTAL) begin
        osc_mode_q <= CRYSTAL_RESONATOR_MODE;
      end else if (osc_select_bits == OSC_SEL_HIGH_SPEED) begin
        osc_mode_q <= HIGH_SPEED_CRYSTAL_MODE;
      end else begin
        osc_mode_q <= RC_OSCILLATOR_MODE;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lp_mode <= 1'b1;
      xt_mode <= 1'b0;
      hs_mode <= 1'b0;
      rc_mode <= 1'b0;
    end else begin
      lp_mode <= osc_mode_q == LOW_POWER_CRYSTAL_MODE;
      xt_mode <= osc_mode_q == CRYSTAL_RESONATOR_MODE;
      hs_mode <= osc_mode_q == HIGH_SPEED_CRYSTAL_MODE;
      rc_mode <= osc_mode_q == RC_OSCILLATOR_MODE;
    end
  end

  // In crystal modes the pin belongs to the oscillator, so keep it low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cycle_clock_q <= 1'b0;
    end else begin
      cycle_clock_q <= (osc_mode_q == RC_OSCILLATOR_MODE) &&
        (pb.phase[PH_IDX_THREE] || pb.phase[PH_IDX_FOUR]);
    end
  end

  // ----------------------------------------------------------------
  // Fetch stage
  // ----------------------------------------------------------------
  // A jump resolves in phase four, the same phase that latches the
  // prefetched word, so that word is dropped right there.
  assign take_branch = exec_valid_q && branch_req &&
    pb.enter[PH_IDX_FOUR];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_q <= PC_RESET;
      prog_addr_q <= PC_RESET;
    end else if (pb.hold) begin
      pc_q <= PC_RESET;
      prog_addr_q <= PC_RESET;
    end else if (pb.enter[PH_IDX_ONE]) begin
      prog_addr_q <= pc_q;
      pc_q <= pc_q + PC_STEP;
    end else if (take_branch) begin
      pc_q <= branch_target;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fetch_q <= INSTR_RESET;
      fetch_valid_q <= 1'b0;
    end else if (pb.hold) begin
      fetch_valid_q <= 1'b0;
    end else if (pb.enter[PH_IDX_FOUR]) begin
      fetch_q <= prog_data;
      fetch_valid_q <= !take_branch;
    end
  end

  // ----------------------------------------------------------------
  // Execute stage
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ir_q <= INSTR_RESET;
      exec_valid_q <= 1'b0;
    end else if (pb.hold) begin
      exec_valid_q <= 1'b0;
    end else if (pb.enter[PH_IDX_ONE]) begin
      ir_q <= fetch_q;
      exec_valid_q <= fetch_valid_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_step_q <= 1'b0;
      dmem_read_q <= 1'b0;
      dmem_write_q <= 1'b0;
    end else begin
      pc_step_q <= pb.enter[PH_IDX_ONE] && !pb.hold;
      // A clear landing on the entry edge must not leak a memory strobe
      dmem_read_q <= pb.enter[PH_IDX_TWO] && exec_valid_q &&
        !pb.hold;
      dmem_write_q <= pb.enter[PH_IDX_FOUR] && exec_valid_q &&
        !pb.hold;
    end
  end

  assign prog_addr = prog_addr_q;
  assign instr_reg = ir_q;
  assign exec_valid = exec_valid_q;
  assign pc_step = pc_step_q;
  assign dmem_read = dmem_read_q;
  assign dmem_write = dmem_write_q;
  assign cycle_clock_out = cycle_clock_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_pc_increment: assert property (
    @(posedge clk) disable iff (!rst_n)
    (pb.enter[PH_IDX_ONE] && !pb.hold) |=>
      pc_q == $past(pc_q) + PC_STEP && pc_step)
    else $error("pc did not step in phase one");

  a_fetch_latch: assert property (
    @(posedge clk) disable iff (!rst_n)
    (pb.enter[PH_IDX_FOUR] && !pb.hold) |=> fetch_q == $past(prog_data))
    else $error("program word not latched in phase four");

  a_ir_load: assert property (
    @(posedge clk) disable iff (!rst_n)
    (pb.enter[PH_IDX_ONE] && !pb.hold) |=>
      ir_q == $past(fetch_q) && exec_valid_q == $past(fetch_valid_q))
    else $error("instruction register not loaded");

  a_operand_read: assert property (
    @(posedge clk) disable iff (!rst_n)
    dmem_read |-> $past(pb.enter[PH_IDX_TWO]) && $past(exec_valid_q))
    else $error("operand read outside phase two");

  a_result_write: assert property (
    @(posedge clk) disable iff (!rst_n)
    dmem_write |-> $past(pb.enter[PH_IDX_FOUR]) && phase_four)
    else $error("result write outside phase four");

  a_branch_flush: assert property (
    @(posedge clk) disable iff (!rst_n)
    (take_branch && !pb.hold) |=>
      !fetch_valid_q && pc_q == $past(branch_target))
    else $error("branch did not flush prefetch");

  a_rc_clock: assert property (
    @(posedge clk) disable iff (!rst_n)
    (osc_mode_q != RC_OSCILLATOR_MODE) |=> !cycle_clock_out)
    else $error("cycle clock driven outside rc mode");

  a_clear_empty: assert property (
    @(posedge clk) disable iff (!rst_n)
    pb.hold |=> !exec_valid && !fetch_valid_q && pc_q == PC_RESET)
    else $error("pipeline not emptied by clear");

endmodule

// *** tb/osc_source.sv ***
`timescale 1ns/1ps
module osc_source #(
  parameter int HALF = 3
) (
  input wire logic clk,        // Bench clock
  input wire logic clear_req,  // Ask for a master clear
  output logic osc_in,         // Oscillator pin level
  output logic master_clear_n  // Master clear pin
);
  // ------------------------------------------------------------
  // Free-running source
  // ------------------------------------------------------------
  // An oscillator keeps running through any reset, so no reset here
  logic osc_q = 1'b0;
  logic clr_n_q = 1'b1;
  int cnt = 0;
  assign osc_in = osc_q;
  assign master_clear_n = clr_n_q;
  always @(posedge clk) begin
    if (cnt == HALF - 1) begin
      cnt <= 0;
      osc_q <= ~osc_q;
    end else begin
      cnt <= cnt + 1;
    end
  end
  always @(posedge clk) begin
    clr_n_q <= ~clear_req;
  end
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/1ps
module testbench
  import qclk_pkg::*;
;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  localparam logic [PC_WIDTH-1:0] JMP_AT = 11'h005;
  localparam logic [PC_WIDTH-1:0] TGT = 11'h040;
  localparam int CYC = 24; // Four phases of a six-clock osc period
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic clear_req = 1'b0;
  logic [1:0] osc_sel = 2'h0;
  logic [INSTR_WIDTH-1:0] prog_data = 12'h000;
  logic branch_req = 1'b0;
  logic [PC_WIDTH-1:0] branch_target = 11'h000;
  logic osc_in, master_clear_n, ph1, ph2, ph3, ph4, exec_valid, pc_step;
  logic dmem_read, dmem_write, cycle_clock_out, lp, xt, hs, rc;
  logic [PC_WIDTH-1:0] prog_addr;
  logic [INSTR_WIDTH-1:0] instr_reg;
  int n_errors = 0;
  int total_checks = 0;
  int rd, wr, st, ck, clks;
  logic bad, ev_prev;

  initial forever #12.5 clk = ~clk;

  osc_source src (.clk(clk), .clear_req(clear_req), .osc_in(osc_in),
    .master_clear_n(master_clear_n));
  quadrature_clock_pipeline uut (.clk(clk), .rst_n(rst_n),
    .osc_in(osc_in), .master_clear_n(master_clear_n),
    .osc_select_bits(osc_sel), .prog_data(prog_data),
    .branch_req(branch_req), .branch_target(branch_target),
    .phase_one(ph1), .phase_two(ph2), .phase_three(ph3),
    .phase_four(ph4), .prog_addr(prog_addr), .instr_reg(instr_reg),
    .exec_valid(exec_valid), .pc_step(pc_step), .dmem_read(dmem_read),
    .dmem_write(dmem_write), .cycle_clock_out(cycle_clock_out),
    .lp_mode(lp), .xt_mode(xt), .hs_mode(hs), .rc_mode(rc));

  // Program memory holds a word tagged with its own address
  always @(posedge clk) begin
    prog_data <= {1'b1, prog_addr};
    branch_req <= exec_valid === 1'b1 && instr_reg === {1'b1, JMP_AT};
    branch_target <= TGT;
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Runs to one clock past the next phase one entry, judging the cycle
  task automatic one_cycle(input bit first);
    logic [3:0] pv, nv;
    logic pc;
    bit rose;
    rd = 0;
    wr = 0;
    st = 0;
    ck = 0;
    clks = 0;
    bad = 1'b0;
    rose = 0;
    pv = {ph4, ph3, ph2, ph1};
    pc = cycle_clock_out;
    while (!rose) begin
      tick();
      nv = {ph4, ph3, ph2, ph1};
      clks++;
      rd += (dmem_read === 1'b1);
      wr += (dmem_write === 1'b1);
      st += (pc_step === 1'b1);
      if (cycle_clock_out === 1'b1 && pc !== 1'b1) ck++;
      pc = cycle_clock_out;
      if (nv !== pv && nv !== {pv[2:0], pv[3]} &&
          !(pv === 4'h0 && nv === 4'h1)) bad = 1'b1;
      rose = nv[0] === 1'b1 && pv[0] !== 1'b1;
      pv = nv;
      if (clks > 200) begin
        n_errors++;
        conclude();
      end
    end
    tick();
    clks++;
    st += (pc_step === 1'b1);
    chk("phase order", 0, bad);
    chk("pc steps", 1, st);
    if (!first) begin
      chk("cycle length", CYC, clks);
      chk("operand reads", ev_prev, rd);
      chk("result writes", ev_prev, wr);
      chk("cycle clock rises", osc_sel == OSC_SEL_RC, ck);
    end
    ev_prev = exec_valid;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic test_start();
    one_cycle(1);
    chk("first fetch address", PC_RESET, prog_addr);
    chk("first exec valid", 0, exec_valid);
    chk("reset mode flag", 1, lp);
    $display("test start done");
  endtask

  task automatic test_pipeline();
    for (int i = 1; i <= 6; i++) begin
      one_cycle(0);
      chk("fetch address", i, prog_addr);
      chk("executing word", {5'h01, 11'(i - 1)}, instr_reg);
      chk("exec valid", 1, exec_valid);
    end
    $display("test pipeline done");
  endtask

  task automatic test_branch();
    one_cycle(0);
    chk("branch fetch address", TGT, prog_addr);
    chk("flushed exec valid", 0, exec_valid);
    one_cycle(0);
    chk("after branch address", TGT + 11'h001, prog_addr);
    chk("target word", {5'h01, TGT}, instr_reg);
    chk("target exec valid", 1, exec_valid);
    $display("test branch done");
  endtask

  task automatic test_modes();
    for (int m = 0; m < 4; m++) begin
      @(posedge clk);
      osc_sel <= 2'(m);
      #1;
      one_cycle(1);
      one_cycle(0);
      chk("mode flags", 16'h0001 << m, {rc, hs, xt, lp});
    end
    $display("test modes done");
  endtask

  task automatic test_clear();
    @(posedge clk);
    clear_req <= 1'b1;
    repeat (12) tick();
    chk("phases in clear", 0, {ph4, ph3, ph2, ph1});
    chk("exec in clear", 0, exec_valid);
    @(posedge clk);
    clear_req <= 1'b0;
    #1;
    one_cycle(1);
    chk("restart address", PC_RESET, prog_addr);
    chk("restart exec valid", 0, exec_valid);
    one_cycle(0);
    chk("second address", PC_STEP, prog_addr);
    $display("test clear done");
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    test_start();
    test_pipeline();
    test_branch();
    test_modes();
    test_clear();
    conclude();
  end
endmodule
